// *** bench/kbil_keypad_interrupt_latch_tb.sv ***
// bench for the keypad latch: apb tasks, key model, checks
// assumes the checker is bound to dut by its own file
`define CHK(n, e, g) begin @(negedge clock); checked++; if ((g) !== (e)) \
	begin nFail++; $display("mismatch %s exp %0h got %0h", n, e, g); end \
	@(posedge clock); end
module kbil_keypad_interrupt_latch_tb
	import kbil_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ns;
	localparam logic [11:0] SC = KBIL_ADDR_STATUS_CONTROL;
	localparam logic [11:0] PE = KBIL_ADDR_PIN_ENABLE;
	logic        clock, arst_n, psel, penable, pwrite, pready, pslverr;
	logic        vectorFetch, breakState, breakClearEnable, rerr;
	logic        interruptRequest, wakeRequest, keypadPendingFlag;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, rdat;
	logic [7:0]  press, keypadInput, portDirection, pullupEnable, pinDirection;
	int          nFail, checked;

	kbil_keypad_interrupt_latch dut (.clock(clock), .arst_n(arst_n),
		.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
		.pwdata(pwdata), .pstrb(4'hF), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .keypadInput(keypadInput),
		.portDirection(portDirection), .vectorFetch(vectorFetch),
		.breakState(breakState), .breakClearEnable(breakClearEnable),
		.pullupEnable(pullupEnable), .pinDirection(pinDirection),
		.interruptRequest(interruptRequest), .wakeRequest(wakeRequest),
		.keypadPendingFlag(keypadPendingFlag));
	kbil_keys u_keys (.press(press), .pullupEnable(pullupEnable),
		.keyLine(keypadInput));

	// 25 MHz
	always #20 clock = ~clock;

	task automatic wrap_up();
		$display("checks %0d mismatches %0d", checked, nFail);
		if (nFail == 0 && checked > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask : wrap_up

	task automatic tick(input int n);
		repeat (n) @(posedge clock);
	endtask : tick

	// pready is read at the rising edge that samples it; read data and
	// the error flag are taken there, and only then is the request released
	task automatic xfer(input logic w, input logic [11:0] a, input logic [7:0] d);
		int i;
		@(posedge clock);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= {24'h000000, d};
		@(posedge clock);
		penable <= 1'b1;
		i = 0;
		do begin
			@(posedge clock);
			i++;
		end while (pready !== 1'b1 && i < 20);
		rdat = prdata;
		rerr = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		if (i >= 20) begin
			nFail++;
			wrap_up();
		end
	endtask : xfer

	task automatic wr(input logic [11:0] a, input logic [7:0] d);
		xfer(1'b1, a, d);
	endtask : wr

	task automatic rd(input logic [11:0] a, input logic [7:0] e);
		xfer(1'b0, a, 8'h00);
		`CHK("rdata", {24'h000000, e}, rdat)
	endtask : rd

	initial begin
		clock = 1'b0;
		arst_n = 1'b0;
		{psel, penable, pwrite, paddr, pwdata} = '0;
		{press, vectorFetch, breakState, breakClearEnable} = '0;
		portDirection = 8'hFF;
		tick(8);
		arst_n <= 1'b1;
		tick(1);
		rd(SC, 8'h00);
		rd(PE, 8'h00);
		// no key line doubles as a timer clock or two-wire pin here
		wr(SC, 8'h02);
		wr(PE, 8'hFF);
		tick(8);
		// keys open: lines already high once pullups settle
		wr(SC, 8'h06);
		wr(SC, 8'h00);
		rd(PE, 8'hFF);
		`CHK("pullup", 8'h3F, pullupEnable)
		`CHK("dir", 8'h00, pinDirection)
		// edge mode: latch, ack, second key while first held
		press <= 8'h01;
		tick(7);
		`CHK("irq", 1'b1, interruptRequest)
		rd(SC, 8'h08);
		wr(SC, 8'h04);
		tick(1);
		`CHK("irq", 1'b0, interruptRequest)
		press <= 8'h03;
		tick(7);
		`CHK("pend", 1'b0, keypadPendingFlag)
		press <= 8'h00;
		tick(7);
		wr(SC, 8'h04);
		press <= 8'h04;
		tick(7);
		`CHK("pend", 1'b1, keypadPendingFlag)
		vectorFetch <= 1'b1;
		tick(1);
		vectorFetch <= 1'b0;
		tick(1);
		`CHK("pend", 1'b0, keypadPendingFlag)
		// masked request still shows as pending; all keys up first
		press <= 8'h00;
		tick(7);
		wr(SC, 8'h02);
		press <= 8'h10;
		tick(7);
		`CHK("pend", 1'b1, keypadPendingFlag)
		`CHK("irq", 1'b0, interruptRequest)
		wr(SC, 8'h00);
		`CHK("wake", 1'b1, wakeRequest)
		press <= 8'h00;
		tick(7);
		wr(SC, 8'h05);
		// level mode, ack first then release
		press <= 8'h20;
		tick(7);
		wr(SC, 8'h05);
		tick(2);
		`CHK("pend", 1'b1, keypadPendingFlag)
		press <= 8'h00;
		tick(7);
		`CHK("pend", 1'b0, keypadPendingFlag)
		// level mode, release first then ack
		press <= 8'h20;
		tick(7);
		press <= 8'h00;
		tick(7);
		rd(SC, 8'h09);
		wr(SC, 8'h05);
		tick(2);
		`CHK("pend", 1'b0, keypadPendingFlag)
		// break state guards the latch unless clear is enabled
		wr(SC, 8'h00);
		breakState <= 1'b1;
		press <= 8'h80;
		tick(7);
		press <= 8'h00;
		wr(SC, 8'h04);
		`CHK("pend", 1'b1, keypadPendingFlag)
		breakClearEnable <= 1'b1;
		wr(SC, 8'h04);
		tick(1);
		`CHK("pend", 1'b0, keypadPendingFlag)
		breakState <= 1'b0;
		// disabled pin is ignored and keeps its direction
		wr(PE, 8'h01);
		portDirection <= 8'h0F;
		press <= 8'h80;
		tick(7);
		`CHK("pend", 1'b0, keypadPendingFlag)
		`CHK("dir", 8'h0E, pinDirection)
		xfer(1'b1, 12'h074, 8'hFF);
		rd(12'h074, 8'h00);
		`CHK("slverr", 1'b1, rerr)
		// reset with a key held low
		wr(SC, 8'h01);
		press <= 8'h01;
		tick(7);
		arst_n <= 1'b0;
		tick(2);
		arst_n <= 1'b1;
		`CHK("pend", 1'b0, keypadPendingFlag)
		rd(SC, 8'h00);
		wrap_up();
	end
endmodule : kbil_keypad_interrupt_latch_tb

// *** bench/kbil_keys.sv ***
// key model on the keypad pins
// assumes a board pullup on pins six and seven only
module kbil_keys
	import kbil_pkg::*;
(
	input  wire logic [KBIL_NUM_INPUTS-1:0] press,
	input  wire logic [KBIL_NUM_INPUTS-1:0] pullupEnable,
	output logic      [KBIL_NUM_INPUTS-1:0] keyLine
);
	// a pressed key pulls low; an unpulled free line sinks to 0,
	// so a disabled pin never hides behind a stale high
	assign keyLine = ~press & (pullupEnable | 8'hC0);
endmodule : kbil_keys

// *** bench/kbil_props.sv ***
// checker for the keypad latch: relations between its ports over time
// assumes it is bound to the top module; one clock, async reset
module kbil_props
	import kbil_pkg::*;
#(
	parameter int NUM_INPUTS = KBIL_NUM_INPUTS
) (
	input wire logic                  clock,
	input wire logic                  arst_n,
	input wire logic                  psel,
	input wire logic                  penable,
	input wire logic                  pwrite,
	input wire logic [11:0]           paddr,
	input wire logic [31:0]           prdata,
	input wire logic                  pready,
	input wire logic                  pslverr,
	input wire logic [NUM_INPUTS-1:0] keypadInput,
	input wire logic [NUM_INPUTS-1:0] portDirection,
	input wire logic [NUM_INPUTS-1:0] pullupEnable,
	input wire logic [NUM_INPUTS-1:0] pinDirection,
	input wire logic                  interruptRequest,
	input wire logic                  wakeRequest,
	input wire logic                  keypadPendingFlag
);
	default clocking cb @(posedge clock); endclocking
	default disable iff (!arst_n);

	// bus steps: setup, then an answered access
	sequence s_setup;
		psel && !penable;
	endsequence
	sequence s_acc;
		psel && penable && pready;
	endsequence
	sequence s_rd(a);
		s_acc ##0 (!pwrite && paddr == a);
	endsequence

	property p_ready;
		s_setup |=> pready;
	endproperty
	property p_err;
		s_acc ##0 (paddr != KBIL_ADDR_STATUS_CONTROL
			&& paddr != KBIL_ADDR_PIN_ENABLE) |-> pslverr;
	endproperty
	property p_rd_sc;
		s_rd(KBIL_ADDR_STATUS_CONTROL) |-> prdata[31:4] == 28'h0
			&& !prdata[2];
	endproperty
	// pullups follow the enable register seen on a read
	property p_rd_pe;
		s_rd(KBIL_ADDR_PIN_ENABLE) |-> prdata[31:8] == 24'h0
			&& prdata[5:0] == pullupEnable[5:0];
	endproperty
	// a new request needs some line low a few clocks earlier
	property p_rise;
		$rose(keypadPendingFlag) |-> $past(keypadInput, 3) != '1
			|| $past(keypadInput, 4) != '1 || $past(keypadInput, 5) != '1;
	endproperty

	a_ready: assert property (p_ready) else $error("no pready");
	a_err: assert property (p_err) else $error("no slverr");
	a_rd_sc: assert property (p_rd_sc) else $error("bad status");
	a_rd_pe: assert property (p_rd_pe) else $error("bad enable");
	a_rise: assert property (p_rise) else $error("no fall");
	a_irq: assert property (interruptRequest |-> keypadPendingFlag)
		else $error("irq w/o pend");
	a_wake: assert property (wakeRequest == interruptRequest)
		else $error("wake differs");
	a_pull: assert property (pullupEnable[7:6] == 2'b00)
		else $error("pullup 6/7");
	a_dir: assert property ((pinDirection & ~$past(portDirection)) == '0)
		else $error("dir not forced");
	a_rst: assert property ($rose(arst_n) |-> !keypadPendingFlag)
		else $error("pend after reset");
endmodule : kbil_props

bind kbil_keypad_interrupt_latch kbil_props #(.NUM_INPUTS(NUM_INPUTS)) u_props (
	.clock(clock), .arst_n(arst_n), .psel(psel), .penable(penable),
	.pwrite(pwrite), .paddr(paddr), .prdata(prdata), .pready(pready),
	.pslverr(pslverr), .keypadInput(keypadInput),
	.portDirection(portDirection), .pullupEnable(pullupEnable),
	.pinDirection(pinDirection), .interruptRequest(interruptRequest),
	.wakeRequest(wakeRequest), .keypadPendingFlag(keypadPendingFlag)
);

// *** hdl/kbil_apb.sv ***
// apb slave front end: decodes access phase into write strobes and an access flag, and the address alone into an unmapped flag
// assumes one wait-free transfer; pready is high in every access phase
module kbil_apb
	import kbil_pkg::*;
(
	input  wire logic          clock,
	input  wire logic          arst_n,
	input  wire kbil_apb_req_t req,
	output logic               writeStatus,
	output logic               writePins,
	output logic               accessNow,
	output logic               unmapped
);
	// combinational decode of the access phase and the address
	always_comb begin
		accessNow   = req.sel && req.enable;
		writeStatus = accessNow && req.write
			&& req.addr == KBIL_ADDR_STATUS_CONTROL;
		writePins   = accessNow && req.write
			&& req.addr == KBIL_ADDR_PIN_ENABLE;
		unmapped    = req.addr != KBIL_ADDR_STATUS_CONTROL
			&& req.addr != KBIL_ADDR_PIN_ENABLE;
	end
endmodule : kbil_apb

// *** hdl/kbil_keypad_interrupt_latch.sv ***
// keypad interrupt latch: eight enabled key inputs, edge or edge-plus-level
// assumes APB master on clock, keypad pins asynchronous, cpu drives fetch
module kbil_keypad_interrupt_latch
	import kbil_pkg::*;
#(
	parameter int NUM_INPUTS = KBIL_NUM_INPUTS
) (
	input  wire logic                  clock,
	input  wire logic                  arst_n,
	input  wire logic                  psel,
	input  wire logic                  penable,
	input  wire logic                  pwrite,
	input  wire logic [11:0]           paddr,
	input  wire logic [31:0]           pwdata,
	input  wire logic [3:0]            pstrb,
	output logic      [31:0]           prdata,
	output logic                       pready,
	output logic                       pslverr,
	input  wire logic [NUM_INPUTS-1:0] keypadInput,
	input  wire logic [NUM_INPUTS-1:0] portDirection,
	input  wire logic                  vectorFetch,
	input  wire logic                  breakState,
	input  wire logic                  breakClearEnable,
	output logic      [NUM_INPUTS-1:0] pullupEnable,
	output logic      [NUM_INPUTS-1:0] pinDirection,
	output logic                       interruptRequest,
	output logic                       wakeRequest,
	output logic                       keypadPendingFlag
);
	typedef enum logic [1:0] {
		KBIL_IDLE,
		KBIL_LATCHED,
		KBIL_ACKED_WAIT
	} kbil_state_t;

	kbil_apb_req_t             apbReq;
	kbil_state_t               state;
	kbil_state_t               next_state;
	logic [NUM_INPUTS-1:0]     keypadSync;
	logic [NUM_INPUTS-1:0]     keypadPinEnable;
	logic                      keypadMask;
	logic                      keypadSensitivity;
	logic                      anyLow;
	logic                      anyLowPrev;
	logic                      fallEvent;
	logic                      ackEvent;
	logic                      writeStatus;
	logic                      writePins;
	logic                      accessNow;
	logic                      unmapped;
	logic                      pending;
	logic                      byteZeroWritten;

	// true when any enabled input is low
	function automatic logic enabledLow(
		input logic [NUM_INPUTS-1:0] level,
		input logic [NUM_INPUTS-1:0] enable
	);
		enabledLow = |(~level & enable);
	endfunction : enabledLow

	assign apbReq = '{sel: psel, enable: penable, write: pwrite,
		addr: paddr, wdata: pwdata};

	kbil_sync #(
		.WIDTH(NUM_INPUTS)
	) u_sync (
		.clock  (clock),
		.arst_n (arst_n),
		.asyncIn(keypadInput),
		.syncOut(keypadSync)
	);

	kbil_apb u_apb (
		.clock      (clock),
		.arst_n     (arst_n),
		.req        (apbReq),
		.writeStatus(writeStatus),
		.writePins  (writePins),
		.accessNow  (accessNow),
		.unmapped   (unmapped)
	);

	// only byte lane zero carries the eight register bits
	assign byteZeroWritten = pstrb[0];

	// pin enable register, one bit per key input
	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			keypadPinEnable <= KBIL_RESET_BYTE;
		end else if (writePins && byteZeroWritten) begin
			keypadPinEnable <= pwdata[NUM_INPUTS-1:0];
		end
	end

	// mask and sensitivity bits of the status and control register
	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			keypadMask        <= 1'b0;
			keypadSensitivity <= 1'b0;
		end else if (writeStatus && byteZeroWritten) begin
			keypadMask        <= pwdata[KBIL_BIT_MASK];
			keypadSensitivity <= pwdata[KBIL_BIT_SENSITIVITY];
		end
	end

	// acknowledge from a vector fetch or a software write of one;
	// during break with clear-enable low the software write is dropped
	always_comb begin
		ackEvent = vectorFetch;
		if (writeStatus && byteZeroWritten && pwdata[KBIL_BIT_ACK]
			&& !(breakState && !breakClearEnable)) begin
			ackEvent = 1'b1;
		end
	end

	// group level: a request arms only when all enabled inputs were high
	assign anyLow = enabledLow(keypadSync, keypadPinEnable);
	assign fallEvent = anyLow && !anyLowPrev;

	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			anyLowPrev <= 1'b0;
		end else begin
			anyLowPrev <= anyLow;
		end
	end

	// request state machine; a new fall beats a same-cycle acknowledge
	always_comb begin
		next_state = state;
		case (state)
			KBIL_IDLE: begin
				if (fallEvent) begin
					next_state = KBIL_LATCHED;
				end
			end
			KBIL_LATCHED: begin
				if (fallEvent) begin
					next_state = KBIL_LATCHED;
				end else if (ackEvent && !keypadSensitivity) begin
					next_state = KBIL_IDLE;
				end else if (ackEvent && !anyLow) begin
					next_state = KBIL_IDLE;
				end else if (ackEvent) begin
					next_state = KBIL_ACKED_WAIT;
				end
			end
			KBIL_ACKED_WAIT: begin
				if (!keypadSensitivity) begin
					next_state = KBIL_IDLE;
				end else if (!anyLow) begin
					next_state = KBIL_IDLE;
				end
			end
			default: begin
				next_state = KBIL_IDLE;
			end
		endcase
	end

	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			state <= KBIL_IDLE;
		end else begin
			state <= next_state;
		end
	end

	// in level mode a low level keeps the request present even after ack
	assign pending = (next_state == KBIL_LATCHED)
		|| (next_state == KBIL_ACKED_WAIT);

	// registered outputs toward the cpu and the pins
	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			keypadPendingFlag <= 1'b0;
			interruptRequest  <= 1'b0;
			wakeRequest       <= 1'b0;
			pullupEnable      <= '0;
			pinDirection      <= '0;
		end else begin
			keypadPendingFlag <= pending;
			interruptRequest  <= pending && !next_mask();
			wakeRequest       <= pending && !next_mask();
			pullupEnable      <= keypadPinEnable
				& pullupPinMap();
			pinDirection      <= portDirection
				& ~keypadPinEnable;
		end
	end

	// mask value that will stand after this edge
	function automatic logic next_mask();
		next_mask = (writeStatus && byteZeroWritten)
			? pwdata[KBIL_BIT_MASK] : keypadMask;
	endfunction : next_mask

	// only the low inputs carry an internal pullup
	function automatic logic [NUM_INPUTS-1:0] pullupPinMap();
		pullupPinMap = '0;
		for (int i = 0; i < KBIL_PULLUP_PINS; i++) begin
			pullupPinMap[i] = 1'b1;
		end
	endfunction : pullupPinMap

	// apb answer: zero wait states, read data registered at setup
	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			prdata  <= '0;
			pready  <= 1'b0;
			pslverr <= 1'b0;
		end else begin
			pready  <= psel && !penable;
			pslverr <= psel && !penable && unmapped;
			prdata  <= '0;
			if (psel && !penable && !pwrite) begin
				if (paddr == KBIL_ADDR_STATUS_CONTROL) begin
					prdata[KBIL_BIT_PENDING]     <= keypadPendingFlag;
					prdata[KBIL_BIT_MASK]        <= keypadMask;
					prdata[KBIL_BIT_SENSITIVITY] <= keypadSensitivity;
				end else if (paddr == KBIL_ADDR_PIN_ENABLE) begin
					prdata[NUM_INPUTS-1:0] <= keypadPinEnable;
				end
			end
		end
	end
endmodule : kbil_keypad_interrupt_latch

// *** hdl/kbil_pkg.sv ***
// package for the keypad interrupt latch: register map, field layout, types
// assumes an APB slave with 32-bit data and byte addressing
package kbil_pkg;
	localparam int          KBIL_NUM_INPUTS = 8;
	localparam int          KBIL_PULLUP_PINS = 6;
	localparam logic [11:0] KBIL_ADDR_STATUS_CONTROL = 12'h06C; // index 1B
	localparam logic [11:0] KBIL_ADDR_PIN_ENABLE     = 12'h070; // index 1C
	localparam logic [7:0]  KBIL_INDEX_STATUS_CONTROL = 8'h1B;
	localparam logic [7:0]  KBIL_INDEX_PIN_ENABLE     = 8'h1C;
	localparam int          KBIL_BIT_SENSITIVITY = 0;
	localparam int          KBIL_BIT_MASK        = 1;
	localparam int          KBIL_BIT_ACK         = 2;
	localparam int          KBIL_BIT_PENDING     = 3;
	localparam logic [7:0]  KBIL_RESET_BYTE      = 8'h00;
	localparam logic [15:0] KBIL_VECTOR_ADDR_HIGH = 16'hFFDC;
	localparam logic [15:0] KBIL_VECTOR_ADDR_LOW  = 16'hFFDD;

	// apb request as seen by the slave
	typedef struct packed {
		logic        sel;
		logic        enable;
		logic        write;
		logic [11:0] addr;
		logic [31:0] wdata;
	} kbil_apb_req_t;

	// system side control levels and strobes
	typedef struct packed {
		logic vectorFetch;
		logic breakState;
		logic breakClearEnable;
	} kbil_sys_t;
endpackage : kbil_pkg

// *** hdl/kbil_sync.sv ***
// three-stage input synchroniser; change accepted when stages two and three agree
// assumes input is asynchronous to clock
module kbil_sync
	import kbil_pkg::*;
#(
	parameter int WIDTH = KBIL_NUM_INPUTS
) (
	input  wire logic             clock,
	input  wire logic             arst_n,
	input  wire logic [WIDTH-1:0] asyncIn,
	output logic      [WIDTH-1:0] syncOut
);
	logic [WIDTH-1:0] stage1;
	logic [WIDTH-1:0] stage2;
	logic [WIDTH-1:0] stage3;

	// pins idle high, so reset to high to avoid a false edge at release
	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			stage1  <= '1;
			stage2  <= '1;
			stage3  <= '1;
			syncOut <= '1;
		end else begin
			stage1 <= asyncIn;
			stage2 <= stage1;
			stage3 <= stage2;
			for (int i = 0; i < WIDTH; i++) begin
				if (stage2[i] == stage3[i]) begin
					syncOut[i] <= stage3[i];
				end
			end
		end
	end
endmodule : kbil_sync
